// >>> hdl/acr_pkg.sv
// package: constants and carrier types for the adc clock, reset and input select core
package acr_pkg;
   // ------------------------------------------------------------
   // timing counts
   // ------------------------------------------------------------
   localparam logic [10:0] POR_HOLD_CLKS = 11'h400;
   localparam logic [12:0] VALID_WAIT_FS = 13'h1194;
   // ------------------------------------------------------------
   // ratio figures, clocks per sample period
   // ------------------------------------------------------------
   localparam logic [10:0] RATIO_256 = 11'h100;
   localparam logic [10:0] RATIO_384 = 11'h180;
   localparam logic [10:0] RATIO_512 = 11'h200;
   localparam logic [10:0] RATIO_768 = 11'h300;
   // midpoints used to pick the nearest ratio
   localparam logic [10:0] MID_256_384 = 11'h140;
   localparam logic [10:0] MID_384_512 = 11'h1C0;
   localparam logic [10:0] MID_512_768 = 11'h280;
   localparam logic [10:0] RATIO_CNT_MAX = 11'h7FF;
   // ------------------------------------------------------------
   // codes and reset values
   // ------------------------------------------------------------
   localparam logic [2:0] SEL_MUTE_LO = 3'h0;
   localparam logic [2:0] SEL_MUTE_HI = 3'h7;
   localparam logic [2:0] SEL_RESET = 3'h1;
   localparam logic [5:0] GAIN_RESET = 6'h0A;
   localparam logic [1:0] MODE_SLAVE = 2'h0;
   localparam logic [1:0] MODE_M256 = 2'h1;
   localparam logic [1:0] MODE_M384 = 2'h2;
   localparam logic [1:0] MODE_M512 = 2'h3;
   localparam int AUDIO_W = 24;

   typedef enum logic [1:0] {
      ACR_R256 = 2'b00,
      ACR_R384 = 2'b01,
      ACR_R512 = 2'b10,
      ACR_R768 = 2'b11
   } acr_ratio_t;

   typedef enum logic [1:0] {
      ACR_POR = 2'b00,
      ACR_HOLD = 2'b01,
      ACR_WAIT = 2'b10,
      ACR_RUN = 2'b11
   } acr_state_t;

   // host settings packet carried as one unit
   typedef struct packed {
      logic [1:0] mode;
      logic [2:0] sel;
      logic [5:0] gain;
   } acr_cfg_t;

   // analog front end controls
   typedef struct packed {
      logic mute;
      logic [2:0] input_idx;
      logic [5:0] gain;
   } acr_afe_t;
endpackage

// >>> hdl/acr_core.sv
// module: clock ratio, power-on reset and input select control core
`timescale 1ns/100ps
`default_nettype none
module acr_core (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic power_good_i,
   input wire logic lrck_i,
   input wire logic fs_high_i,
   input wire logic cfg_valid_i,
   input wire acr_pkg::acr_cfg_t cfg_i,
   input wire logic [acr_pkg::AUDIO_W-1:0] adc_data_i,
   output logic [acr_pkg::AUDIO_W-1:0] audio_o,
   output logic audio_valid_o,
   output logic internal_reset_o,
   output logic filter_clk_o,
   output logic mod_clk_o,
   output acr_pkg::acr_ratio_t ratio_o,
   output logic ratio_err_o,
   output acr_pkg::acr_afe_t afe_o
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      acr_pkg::acr_state_t st;
      logic [10:0] hold_cnt;
      logic [12:0] fs_cnt;
      logic [10:0] per_cnt;
      logic lrck_d;
      acr_pkg::acr_ratio_t det;
      acr_pkg::acr_ratio_t ratio;
      logic err;
      logic [9:0] div;
      logic [1:0] mode;
      acr_pkg::acr_afe_t afe;
      logic [acr_pkg::AUDIO_W-1:0] audio;
      logic valid;
      logic ireset;
      logic fclk;
      logic mclk;
   } acr_reg_t;

   acr_reg_t r;
   acr_reg_t next_r;

   // nearest supported ratio for a measured period
   function automatic acr_pkg::acr_ratio_t nearest(input logic [10:0] n);
      if (n < acr_pkg::MID_256_384) begin
         nearest = acr_pkg::ACR_R256;
      end else if (n < acr_pkg::MID_384_512) begin
         nearest = acr_pkg::ACR_R384;
      end else if (n < acr_pkg::MID_512_768) begin
         nearest = acr_pkg::ACR_R512;
      end else begin
         nearest = acr_pkg::ACR_R768;
      end
   endfunction

   // clocks per half 128 fs period is ratio/256; 384 uses 3, a half 64 fs period
   function automatic logic [9:0] half_div(input acr_pkg::acr_ratio_t q);
      case (q)
         acr_pkg::ACR_R256: half_div = 10'h001;
         acr_pkg::ACR_R384: half_div = 10'h003;
         acr_pkg::ACR_R512: half_div = 10'h002;
         acr_pkg::ACR_R768: half_div = 10'h003;
         default: half_div = 10'h001;
      endcase
   endfunction

   logic lrck_rise;
   logic [9:0] fdiv;
   assign lrck_rise = lrck_i & ~r.lrck_d;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.lrck_d = lrck_i;
      // host settings apply on the cycle after the packet
      if (cfg_valid_i) begin
         next_r.mode = cfg_i.mode;
         next_r.afe.gain = cfg_i.gain;
         next_r.afe.mute = (cfg_i.sel == acr_pkg::SEL_MUTE_LO) ||
            (cfg_i.sel == acr_pkg::SEL_MUTE_HI);
         next_r.afe.input_idx = cfg_i.sel;
      end
      // ratio source: measured in slave, programmed in master
      case (r.mode)
         acr_pkg::MODE_M256: next_r.ratio = acr_pkg::ACR_R256;
         acr_pkg::MODE_M384: next_r.ratio = acr_pkg::ACR_R384;
         acr_pkg::MODE_M512: next_r.ratio = acr_pkg::ACR_R512;
         default: next_r.ratio = r.det;
      endcase
      // 768 fs is flagged as illegal only at high sample rates; master modes never select it
      next_r.err = (next_r.ratio == acr_pkg::ACR_R768) && fs_high_i;
      // period counter; saturates so a stopped frame clock is harmless
      if (lrck_rise) begin
         next_r.per_cnt = 11'h001;
         if (r.per_cnt != 11'h000) begin
            next_r.det = nearest(r.per_cnt);
         end
      end else if (r.per_cnt != acr_pkg::RATIO_CNT_MAX) begin
         next_r.per_cnt = r.per_cnt + 11'h001;
      end
      // 128 fs and 64 fs dividers; 384 and 768 use 3-clock halves
      fdiv = half_div(r.ratio);
      if (r.div + 10'h001 >= fdiv) begin
         next_r.div = 10'h000;
         next_r.fclk = ~r.fclk;
         if (r.fclk) begin
            next_r.mclk = ~r.mclk;
         end
      end else begin
         next_r.div = r.div + 10'h001;
      end
      // power-on reset sequence
      case (r.st)
         acr_pkg::ACR_POR: begin
            next_r.hold_cnt = 11'h000;
            if (power_good_i) begin
               next_r.st = acr_pkg::ACR_HOLD;
            end
         end
         acr_pkg::ACR_HOLD: begin
            next_r.hold_cnt = r.hold_cnt + 11'h001;
            if (r.hold_cnt + 11'h001 == acr_pkg::POR_HOLD_CLKS) begin
               next_r.st = acr_pkg::ACR_WAIT;
               next_r.fs_cnt = 13'h0000;
            end
         end
         acr_pkg::ACR_WAIT: begin
            if (lrck_rise) begin
               next_r.fs_cnt = r.fs_cnt + 13'h0001;
               if (r.fs_cnt + 13'h0001 == acr_pkg::VALID_WAIT_FS) begin
                  next_r.st = acr_pkg::ACR_RUN;
               end
            end
         end
         acr_pkg::ACR_RUN: begin
            next_r.st = acr_pkg::ACR_RUN;
         end
         default: next_r.st = acr_pkg::ACR_POR;
      endcase
      // power loss restarts the sequence at once
      if (!power_good_i) begin
         next_r.st = acr_pkg::ACR_POR;
      end
      next_r.ireset = (next_r.st == acr_pkg::ACR_POR) ||
         (next_r.st == acr_pkg::ACR_HOLD);
      next_r.valid = next_r.st == acr_pkg::ACR_RUN;
      // zero data until valid; pops from switching are not filtered here
      next_r.audio = next_r.valid ? adc_data_i : '0;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         r <= '0;
         r.ireset <= 1'b1;
         r.afe.input_idx <= acr_pkg::SEL_RESET;
         r.afe.gain <= acr_pkg::GAIN_RESET;
         r.mode <= acr_pkg::MODE_SLAVE;
      end else begin
         r <= next_r;
      end
   end

   assign audio_o = r.audio;
   assign audio_valid_o = r.valid;
   assign internal_reset_o = r.ireset;
   assign filter_clk_o = r.fclk;
   assign mod_clk_o = r.mclk;
   assign ratio_o = r.ratio;
   assign ratio_err_o = r.err;
   assign afe_o = r.afe;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   int hold_seen;
   always_ff @(posedge clk_i) begin
      if (reset_i || !r.ireset) begin
         hold_seen <= 0;
      end else if (r.st == acr_pkg::ACR_HOLD) begin
         hold_seen <= hold_seen + 1;
      end
   end

   sequence s_cfg_in;
      cfg_valid_i && !reset_i;
   endsequence

   zero_in_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
      r.ireset |-> audio_o == '0) else $error("audio not zero in reset");
   hold_len_a: assert property (@(posedge clk_i) disable iff (reset_i)
      hold_seen <= int'(acr_pkg::POR_HOLD_CLKS))
      else $error("reset held too long");
   release_cnt_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(r.ireset) |-> $past(hold_seen) == int'(acr_pkg::POR_HOLD_CLKS) - 1)
      else $error("reset released at wrong count");
   valid_late_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(audio_valid_o) |-> r.fs_cnt == acr_pkg::VALID_WAIT_FS)
      else $error("valid before wait ended");
   sel_apply_a: assert property (@(posedge clk_i) disable iff (reset_i)
      s_cfg_in |=> afe_o.input_idx == $past(cfg_i.sel))
      else $error("select not applied next cycle");
   mute_code_a: assert property (@(posedge clk_i) disable iff (reset_i)
      afe_o.mute == (afe_o.input_idx == 3'h0 || afe_o.input_idx == 3'h7))
      else $error("mute decode wrong");
   master_ratio_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (r.mode == acr_pkg::MODE_M384) |=> ratio_o == acr_pkg::ACR_R384)
      else $error("master ratio not applied");
   mod_half_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(mod_clk_o) |-> $rose(filter_clk_o) || $fell(filter_clk_o))
      else $error("modulator clock not from filter clock");
   gain_apply_a: assert property (@(posedge clk_i) disable iff (reset_i)
      s_cfg_in |=> afe_o.gain == $past(cfg_i.gain))
      else $error("gain not applied");

   // ------------------------------------------------------------
   // ratio, divider and sequence checks
   // ------------------------------------------------------------
   // a frame edge counts only once the period counter has left zero after reset
   sequence s_frame_edge;
      lrck_rise && (r.per_cnt != 11'h000) && !reset_i;
   endsequence

   sequence s_short_frame;
      s_frame_edge ##0 (r.per_cnt < acr_pkg::MID_256_384);
   endsequence

   sequence s_mid_frame;
      s_frame_edge ##0 (r.per_cnt >= acr_pkg::MID_384_512) ##0
         (r.per_cnt < acr_pkg::MID_512_768);
   endsequence

   sequence s_long_frame;
      s_frame_edge ##0 (r.per_cnt >= acr_pkg::MID_512_768);
   endsequence

   // thresholds come from the package figures, not from the function
   near_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
      s_short_frame |=> r.det == acr_pkg::ACR_R256)
      else $error("short frame not mapped to lowest ratio");
   near_mid_a: assert property (@(posedge clk_i) disable iff (reset_i)
      s_mid_frame |=> r.det == acr_pkg::ACR_R512)
      else $error("middle frame not mapped to 512 ratio");
   near_high_a: assert property (@(posedge clk_i) disable iff (reset_i)
      s_long_frame |=> r.det == acr_pkg::ACR_R768)
      else $error("long frame not mapped to highest ratio");
   // slave path follows the detector; master path takes the code
   slave_ratio_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (r.mode == acr_pkg::MODE_SLAVE) |=> ratio_o == $past(r.det))
      else $error("slave ratio does not follow detector");
   low_master_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (r.mode == acr_pkg::MODE_M256) |=> ratio_o == acr_pkg::ACR_R256)
      else $error("master 256 ratio not applied");
   top_master_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (r.mode == acr_pkg::MODE_M512) |=> ratio_o == acr_pkg::ACR_R512)
      else $error("master 512 ratio not applied");
   // master mode can never land on the slave-only ratio
   master_cap_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (r.mode != acr_pkg::MODE_SLAVE) |=> ratio_o != acr_pkg::ACR_R768)
      else $error("768 ratio used in master mode");
   err_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ratio_err_o == ((ratio_o == acr_pkg::ACR_R768) && $past(fs_high_i)))
      else $error("ratio error flag wrong");

   // neither filter clock phase outlasts the longest half period
   sequence s_fclk_up;
      $rose(filter_clk_o);
   endsequence

   sequence s_fclk_down;
      $fell(filter_clk_o);
   endsequence

   fclk_half_a: assert property (@(posedge clk_i) disable iff (reset_i)
      s_fclk_up |-> ##[1:3] !filter_clk_o)
      else $error("filter clock high too long");
   fclk_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
      s_fclk_down |-> ##[1:3] filter_clk_o)
      else $error("filter clock low too long");

   // reset and valid never overlap; loss of power resets at once
   valid_excl_a: assert property (@(posedge clk_i) disable iff (reset_i)
      audio_valid_o |-> !internal_reset_o)
      else $error("valid during internal reset");
   pwr_loss_a: assert property (@(posedge clk_i) disable iff (reset_i)
      !power_good_i |=> internal_reset_o && !audio_valid_o)
      else $error("power loss did not reset");
   // data passes straight through once the wait has ended
   data_pass_a: assert property (@(posedge clk_i) disable iff (reset_i)
      audio_valid_o |-> audio_o == $past(adc_data_i))
      else $error("valid data not passed through");
   // the first cycles after release still sit inside the wait
   early_quiet_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(internal_reset_o) |-> (!audio_valid_o) [*8])
      else $error("valid too soon after release");
   // reset leaves input one selected at the default gain
   reset_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(reset_i) |-> (afe_o.input_idx == acr_pkg::SEL_RESET) &&
         !afe_o.mute && (afe_o.gain == acr_pkg::GAIN_RESET))
      else $error("reset selection wrong");
endmodule
`default_nettype wire

// >>> testbench/acr_host.sv
// host model: sends settings packets to the control core
`timescale 1ns/100ps
`default_nettype none
module acr_host (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic send_i,
   input wire acr_pkg::acr_cfg_t send_cfg_i,
   output logic cfg_valid_o,
   output acr_pkg::acr_cfg_t cfg_o
);
   // one-cycle strobe per packet; fields scramble between packets so
   // nothing downstream can lean on stale values
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cfg_valid_o <= 1'b0;
         cfg_o <= '0;
      end else begin
         cfg_valid_o <= send_i;
         cfg_o <= send_i ? send_cfg_i : ~cfg_o;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/adc_clock_reset_input_select_tb.sv
// testbench for the clock ratio, reset and input select core
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
   $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module adc_clock_reset_input_select_tb;
   logic clk_i = 0, reset_i = 1, power_good_i = 0, lrck_i = 0;
   logic fs_high_i = 0, send = 0, cfg_v, audio_valid_o, internal_reset_o;
   logic filt, modc, rerr;
   logic [acr_pkg::AUDIO_W-1:0] adc = '0, audio_o;
   acr_pkg::acr_cfg_t scfg = '0, cfg;
   acr_pkg::acr_ratio_t ratio_o;
   acr_pkg::acr_afe_t afe;
   int per = 4, bad_count = 0, checks = 0;
   acr_host host (.clk_i, .reset_i, .send_i(send), .send_cfg_i(scfg),
      .cfg_valid_o(cfg_v), .cfg_o(cfg));
   acr_core dut (.clk_i, .reset_i, .power_good_i, .lrck_i, .fs_high_i,
      .cfg_valid_i(cfg_v), .cfg_i(cfg), .adc_data_i(adc), .audio_o,
      .audio_valid_o, .internal_reset_o, .filter_clk_o(filt),
      .mod_clk_o(modc), .ratio_o, .ratio_err_o(rerr), .afe_o(afe));
   // ------------------------------------------------------------
   // clock, frame clock, watchdog
   // ------------------------------------------------------------
   initial forever #5 clk_i = ~clk_i;
   // frame period follows per, so the ratio seen by the core is per
   initial forever begin
      repeat (per / 2) @(posedge clk_i);
      lrck_i <= 1'b1;
      repeat (per - per / 2) @(posedge clk_i);
      lrck_i <= 1'b0;
   end
   // whole run is near 30k cycles; 60k means a hang
   initial begin
      #600000;
      bad_count++;
      give_verdict();
   end
   task automatic tick;
      @(posedge clk_i) #1;
   endtask
   task automatic give_verdict;
      $display("checks=%0d errors=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic send_cfg(input logic [1:0] m, input logic [2:0] s,
         input logic [5:0] g);
      @(posedge clk_i);
      send <= 1'b1;
      scfg <= '{m, s, g};
      @(posedge clk_i);
      send <= 1'b0;
      tick;
      `CHK(afe.mute, (s == 3'h0 || s == 3'h7))
      `CHK(afe.input_idx, s)
      `CHK(afe.gain, g)
   endtask
   // measures a divided clock half period in system clocks
   task automatic half_per(input bit m, output int n);
      logic v;
      int k;
      v = m ? modc : filt;
      for (k = 0; k < 40 && (m ? modc : filt) === v; k++) tick;
      v = m ? modc : filt;
      for (n = 0; n < 40 && (m ? modc : filt) === v; n++) tick;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_sel;
      int i;
      `CHK(afe, {1'b0, acr_pkg::SEL_RESET, acr_pkg::GAIN_RESET})
      for (i = 0; i < 8; i++) send_cfg(2'h0, 3'(i), 6'(8'h20 + i));
      // back-to-back packets each land at once
      @(posedge clk_i);
      send <= 1'b1;
      scfg <= '{2'h0, 3'h2, 6'h11};
      @(posedge clk_i);
      scfg <= '{2'h0, 3'h5, 6'h12};
      @(posedge clk_i);
      send <= 1'b0;
      #1;
      `CHK(afe, {1'b0, 3'h2, 6'h11})
      tick;
      `CHK(afe, {1'b0, 3'h5, 6'h12})
   endtask
   task automatic t_por;
      int n;
      @(posedge clk_i);
      power_good_i <= 1'b1;
      adc <= 24'hFFFFFF;
      for (n = 0; n < 1100 && internal_reset_o !== 1'b0; n++) begin
         tick;
         if (internal_reset_o) `CHK(audio_o, 24'h0)
      end
      `CHK(n, int'(acr_pkg::POR_HOLD_CLKS) + 1)
   endtask
   task automatic t_valid;
      int n, r;
      logic p;
      r = 0;
      p = lrck_i;
      for (n = 0; n < 30000 && audio_valid_o !== 1'b1; n++) begin
         `CHK(audio_o, 24'h0)
         if (lrck_i && !p) r++;
         p = lrck_i;
         tick;
      end
      `CHK(r, int'(acr_pkg::VALID_WAIT_FS))
      @(posedge clk_i);
      adc <= 24'h5A3C96;
      tick;
      tick;
      `CHK(audio_o, 24'h5A3C96)
   endtask
   task automatic t_ratio;
      int pt[7] = '{256, 319, 320, 447, 448, 639, 640};
      logic [1:0] rt[7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
      int hf[4] = '{1, 3, 2, 3};
      int i, h;
      for (i = 0; i < 7; i++) begin
         per = pt[i];
         repeat (3 * pt[i] + 8) tick;
         `CHK(ratio_o, rt[i])
         half_per(1'b0, h);
         `CHK(h, hf[rt[i]])
         half_per(1'b1, h);
         `CHK(h, 2 * hf[rt[i]])
      end
      `CHK(rerr, 1'b0)
      @(posedge clk_i);
      fs_high_i <= 1'b1;
      repeat (4) tick;
      `CHK(rerr, 1'b1)
      @(posedge clk_i);
      fs_high_i <= 1'b0;
   endtask
   task automatic t_master;
      int m;
      for (m = 1; m < 4; m++) begin
         send_cfg(2'(m), 3'h1, acr_pkg::GAIN_RESET);
         tick;
         `CHK(ratio_o, 2'(m - 1))
      end
      send_cfg(acr_pkg::MODE_SLAVE, 3'h1, acr_pkg::GAIN_RESET);
      repeat (3 * 640) tick;
      `CHK(ratio_o, 2'h3)
   endtask
   task automatic t_off;
      @(posedge clk_i);
      power_good_i <= 1'b0;
      tick;
      tick;
      `CHK(internal_reset_o, 1'b1)
      `CHK(audio_o, 24'h0)
      `CHK(audio_valid_o, 1'b0)
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      tick;
      t_sel();
      t_por();
      t_valid();
      t_ratio();
      t_master();
      t_off();
      give_verdict();
   end
endmodule
`default_nettype wire
